/* logic/rpm_pkg.sv */
// Package: register map, fields and mode encodings for power-mode control
package rpm_pkg;

	// ---------------------------------------------------------------
	// Register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [11:0] ADDR_POWER_CTRL = 12'h000;
	localparam logic [11:0] ADDR_CLOCK_CTRL = 12'h004;
	localparam logic [11:0] ADDR_PORT_SEL   = 12'h008;
	localparam logic [11:0] ADDR_STATUS     = 12'h00c;
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h010;
	localparam logic [11:0] ADDR_IRQ_MASK   = 12'h014;
	localparam logic [11:0] ADDR_MODE       = 12'h018;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int BIT_TOTAL_PD   = 0;
	localparam int BIT_LINK_PD    = 1;
	localparam int BIT_AUDIO_PD   = 2;
	localparam int BIT_VIDEO_PD   = 3;
	localparam int BIT_MCLK_PD    = 0;
	localparam int BIT_XTAL_PD    = 1;
	localparam int BIT_APLL_PD    = 2;
	localparam int BIT_PCLK_PD    = 3;
	localparam int BIT_CLK_DET    = 0;
	localparam int BIT_SYNC_DET   = 1;
	localparam int BIT_IRQ_CLK    = 0;
	localparam int BIT_IRQ_SYNC   = 1;
	localparam int BIT_IRQ_MODE   = 2;
	localparam int PORTS          = 4;
	localparam int PORT_W         = 2;
	localparam int PD_W           = 4;
	localparam int IRQ_W          = 3;
	localparam int STAT_W         = 2;
	localparam int MODE_W         = 5;

	// ---------------------------------------------------------------
	// Reset values: all power-down controls inactive (high)
	// ---------------------------------------------------------------
	localparam logic [PD_W-1:0]   POWER_CTRL_RST = 4'hf;
	localparam logic [PD_W-1:0]   CLOCK_CTRL_RST = 4'hf;
	localparam logic [PORT_W-1:0] PORT_SEL_RST   = 2'h0;
	localparam logic [IRQ_W-1:0]  IRQ_MASK_RST   = 3'h0;
	localparam logic [PD_W-1:0]   PD_ALL_HIGH    = 4'hf;
	localparam logic [PD_W-1:0]   PD_TOTAL_ONLY  = 4'he;
	localparam logic [PD_W-1:0]   PD_LINK_ONLY   = 4'hd;
	localparam logic [PD_W-1:0]   PD_OUTS_ONLY   = 4'h3;

	// ---------------------------------------------------------------
	// Power modes, one-hot
	// ---------------------------------------------------------------
	typedef enum logic [MODE_W-1:0] {
		RPM_MODE_FULL     = 5'h01,
		RPM_MODE_OFF      = 5'h02,
		RPM_MODE_SLEEP    = 5'h04,
		RPM_MODE_UNSEL    = 5'h08,
		RPM_MODE_OTHER    = 5'h10
	} rpm_mode_t;

endpackage : rpm_pkg

/* logic/rpm_mode_decode.sv */
// Decoder from power-down bits to one-hot power mode
`timescale 1ns/1ps

module rpm_mode_decode
(
	input  wire logic [3:0]        pd_bits_n,
	output rpm_pkg::rpm_mode_t     mode
);

	// Decode named bit patterns, anything else is an other mode
	always_comb
	begin
		case (pd_bits_n)
			rpm_pkg::PD_ALL_HIGH:   mode = rpm_pkg::RPM_MODE_FULL;
			rpm_pkg::PD_TOTAL_ONLY: mode = rpm_pkg::RPM_MODE_OFF;
			rpm_pkg::PD_LINK_ONLY:  mode = rpm_pkg::RPM_MODE_SLEEP;
			rpm_pkg::PD_OUTS_ONLY:  mode = rpm_pkg::RPM_MODE_UNSEL;
			default:                mode = rpm_pkg::RPM_MODE_OTHER;
		endcase
	end

endmodule : rpm_mode_decode

/* logic/rpm_sync_edge.sv */
// Level synchroniser-free event detector for status inputs
`timescale 1ns/1ps

module rpm_sync_edge
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic level_in,
	output logic      level_reg,
	output wire logic changed
);

	// Register level to find changes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			level_reg <= 1'b0;
		else
			level_reg <= level_in;
	end

	assign changed = level_reg ^ level_in;

endmodule : rpm_sync_edge

/* logic/rpm_power_ctrl.sv */
// Power-mode control top with APB register slave
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps

module rpm_power_ctrl
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output wire logic        pready,
	output wire logic        pslverr,
	input  wire logic        link_clock_present,
	input  wire logic        link_sync_present,
	output logic      [3:0]  port_termination_en,
	output logic      [3:0]  port_core_en,
	output logic             clock_detect_en,
	output logic             sync_detect_en,
	output logic             decrypt_en,
	output logic             link_core_en,
	output logic             audio_out_oe,
	output logic             video_out_oe,
	output logic             master_audio_clock_powerdown_n,
	output logic             crystal_powerdown_n,
	output logic             audio_pll_powerdown_n,
	output logic             pixel_clock_powerdown_n,
	output wire logic        irq
);

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [3:0] power_ctrl_reg;
	logic [3:0] clock_ctrl_reg;
	logic [1:0] port_sel_reg;
	logic [2:0] irq_status_reg;
	logic [2:0] irq_status_next;
	logic [2:0] irq_mask_reg;
	logic       clk_det_reg;
	logic       sync_det_reg;
	logic       link_clock_detected;
	logic       sync_detected;
	wire logic  clk_changed;
	wire logic  sync_changed;
	rpm_pkg::rpm_mode_t mode;
	rpm_pkg::rpm_mode_t mode_reg;

	// Power-down controls are kept exactly as written. The decoded mode
	// is only read back and used for the change event; the gating
	// below works bit by bit, so it needs no decoded mode at all.

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	wire logic access  = psel && penable;
	wire logic wr_en   = access && pwrite;
	wire logic hit_pwr = paddr == rpm_pkg::ADDR_POWER_CTRL;
	wire logic hit_clk = paddr == rpm_pkg::ADDR_CLOCK_CTRL;
	wire logic hit_prt = paddr == rpm_pkg::ADDR_PORT_SEL;
	wire logic hit_sta = paddr == rpm_pkg::ADDR_STATUS;
	wire logic hit_irs = paddr == rpm_pkg::ADDR_IRQ_STATUS;
	wire logic hit_irm = paddr == rpm_pkg::ADDR_IRQ_MASK;
	wire logic hit_mod = paddr == rpm_pkg::ADDR_MODE;
	wire logic mapped  = hit_pwr | hit_clk | hit_prt | hit_sta
		| hit_irs | hit_irm | hit_mod;

	// Zero wait states; bus runs on pclk, never on the link clock, so
	// registers stay reachable in every power mode, even with no link.
	// The access phase is therefore always a single cycle.
	assign pready  = 1'b1;

	// Unmapped address: error in the access phase, write is dropped
	// because no hit term is set, read data come back as zero
	assign pslverr = access && !mapped;

	// Power-down bits held by software, active low
	wire logic total_powerdown_n      = power_ctrl_reg[rpm_pkg::BIT_TOTAL_PD];
	wire logic link_core_powerdown_n  = power_ctrl_reg[rpm_pkg::BIT_LINK_PD];
	wire logic audio_out_powerdown_n  = power_ctrl_reg[rpm_pkg::BIT_AUDIO_PD];
	wire logic video_out_powerdown_n  = power_ctrl_reg[rpm_pkg::BIT_VIDEO_PD];

	// ---------------------------------------------------------------
	// Mode decode
	// ---------------------------------------------------------------
	rpm_mode_decode u_decode
	(
		.pd_bits_n (power_ctrl_reg),
		.mode      (mode)
	);

	// ---------------------------------------------------------------
	// Status change detectors
	// ---------------------------------------------------------------
	// Each detector keeps the last level for the status register and
	// flags a change for the interrupt logic in the same cycle
	rpm_sync_edge u_clk_edge
	(
		.pclk      (pclk),
		.presetn   (presetn),
		.level_in  (link_clock_detected),
		.level_reg (clk_det_reg),
		.changed   (clk_changed)
	);

	rpm_sync_edge u_sync_edge
	(
		.pclk      (pclk),
		.presetn   (presetn),
		.level_in  (sync_detected),
		.level_reg (sync_det_reg),
		.changed   (sync_changed)
	);

	// ---------------------------------------------------------------
	// Software registers
	// ---------------------------------------------------------------
	// Writes take effect at the access edge; only the low bits of
	// each word are stored, the rest read back as zero. The status
	// register is read-only and the event register is handled below.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			power_ctrl_reg <= rpm_pkg::POWER_CTRL_RST;
			clock_ctrl_reg <= rpm_pkg::CLOCK_CTRL_RST;
			port_sel_reg   <= rpm_pkg::PORT_SEL_RST;
			irq_mask_reg   <= rpm_pkg::IRQ_MASK_RST;
		end
		else if (wr_en)
		begin
			if (hit_pwr)
				power_ctrl_reg <= pwdata[3:0];
			if (hit_clk)
				clock_ctrl_reg <= pwdata[3:0];
			if (hit_prt)
				port_sel_reg <= pwdata[1:0];
			if (hit_irm)
				irq_mask_reg <= pwdata[2:0];
		end
	end

	// Mode register for change event; it resets to full mode, the mode
	// that the reset value of the power-down bits decodes to, so no
	// false event follows reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode_reg <= rpm_pkg::RPM_MODE_FULL;
		else
			mode_reg <= mode;
	end

	// ---------------------------------------------------------------
	// Gating per mode
	// ---------------------------------------------------------------
	// Bits are applied in order of reach, total over link core over
	// outputs, so a pattern outside the named modes still gates
	// safely: a low bit switches off everything behind its part
	wire logic is_off   = !total_powerdown_n;
	wire logic core_on  = !is_off && link_core_powerdown_n;
	wire logic outs_on  = core_on && audio_out_powerdown_n
		&& video_out_powerdown_n;

	// ---------------------------------------------------------------
	// Port selection
	// ---------------------------------------------------------------
	// One-hot port selection, only one port active; a two-bit select
	// cannot name two ports, so no second port can ever be enabled
	function automatic logic [3:0] rpm_onehot(input logic [1:0] sel);
		rpm_onehot = 4'h1 << sel;
	endfunction : rpm_onehot

	wire logic [3:0] sel_hot = rpm_onehot(port_sel_reg);

	// Clock detect runs unless powered fully off; sync needs the core.
	// Each raw level is qualified by its enable, so a detector that is
	// powered down reads as no clock or no sync in the status register
	// and raises one change event if it is switched off while its level is present.
	assign link_clock_detected = clock_detect_en && link_clock_present;
	assign sync_detected       = sync_detect_en && link_sync_present;

	// Next values of the enable outputs
	wire logic [3:0] term_next    = is_off ? 4'h0 : 4'hf;
	wire logic [3:0] port_next    = core_on ? sel_hot : 4'h0;
	wire logic       clkdet_next  = !is_off;
	wire logic       syncdet_next = core_on;
	wire logic       crypt_next   = core_on;
	wire logic       core_next    = core_on;
	wire logic       outs_next    = outs_on;

	// Enable outputs, registered so that no gate glitches on a write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			port_termination_en <= 4'h0;
			port_core_en        <= 4'h0;
			clock_detect_en     <= 1'b0;
			sync_detect_en      <= 1'b0;
			decrypt_en          <= 1'b0;
			link_core_en        <= 1'b0;
			audio_out_oe        <= 1'b0;
			video_out_oe        <= 1'b0;
		end
		else
		begin
			port_termination_en <= term_next;
			port_core_en        <= port_next;
			clock_detect_en     <= clkdet_next;
			sync_detect_en      <= syncdet_next;
			decrypt_en          <= crypt_next;
			link_core_en        <= core_next;
			audio_out_oe        <= outs_next;
			video_out_oe        <= outs_next;
		end
	end

	// ---------------------------------------------------------------
	// Clock power-down group
	// ---------------------------------------------------------------
	// Clock power-down outputs follow the group register. Keeping the
	// four controls in step is the host's duty; the hardware passes
	// each bit on as written and does not force the group together.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			master_audio_clock_powerdown_n <= 1'b1;
			crystal_powerdown_n            <= 1'b1;
			audio_pll_powerdown_n          <= 1'b1;
			pixel_clock_powerdown_n        <= 1'b1;
		end
		else
		begin
			master_audio_clock_powerdown_n <=
				clock_ctrl_reg[rpm_pkg::BIT_MCLK_PD];
			crystal_powerdown_n <= clock_ctrl_reg[rpm_pkg::BIT_XTAL_PD];
			audio_pll_powerdown_n <= clock_ctrl_reg[rpm_pkg::BIT_APLL_PD];
			pixel_clock_powerdown_n <= clock_ctrl_reg[rpm_pkg::BIT_PCLK_PD];
		end
	end

	// ---------------------------------------------------------------
	// Interrupts: set wins over write-one-to-clear
	// ---------------------------------------------------------------
	// Events: mode change, sync change and clock change. An event in the
	// cycle of a clearing write keeps its bit set, so none is lost; the
	// host sees it on its next read and clears it again.
	wire logic [2:0] irq_set = {mode != mode_reg, sync_changed, clk_changed};
	wire logic [2:0] irq_clr = (wr_en && hit_irs) ? pwdata[2:0] : 3'h0;

	always_comb
	begin
		irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_status_reg <= 3'h0;
		else
			irq_status_reg <= irq_status_next;
	end

	assign irq = |(irq_status_reg & irq_mask_reg);

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	wire logic [31:0] rd_mux =
		hit_pwr ? {28'h0, power_ctrl_reg} :
		hit_clk ? {28'h0, clock_ctrl_reg} :
		hit_prt ? {30'h0, port_sel_reg} :
		hit_sta ? {30'h0, sync_det_reg, clk_det_reg} :
		hit_irs ? {29'h0, irq_status_reg} :
		hit_irm ? {29'h0, irq_mask_reg} :
		hit_mod ? {27'h0, mode} :
		32'h0;

	// Read data registered on setup phase, stable in access; reads have
	// no side effect, the event bits clear only on a write of ones.
	// Writes leave the read register alone, so it holds the last read.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite)
			prdata <= rd_mux;
	end

endmodule : rpm_power_ctrl

/* sim/rpm_link_src.sv */
// Link source model: raw clock and sync activity seen by the receiver
`timescale 1ns/1ps

module rpm_link_src
(
	input  wire logic clk_on,
	input  wire logic sync_on,
	output wire logic link_clock_present,
	output wire logic link_sync_present
);
	// Activity levels follow the source's on/off commands
	assign link_clock_present = clk_on;
	assign link_sync_present  = sync_on;
endmodule : rpm_link_src

/* sim/rpm_checker.sv */
// Checker: port-level assertions for power-mode control
`timescale 1ns/1ps

module rpm_checker
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [3:0]  port_termination_en,
	input wire logic [3:0]  port_core_en,
	input wire logic        clock_detect_en,
	input wire logic        sync_detect_en,
	input wire logic        decrypt_en,
	input wire logic        link_core_en,
	input wire logic        audio_out_oe,
	input wire logic        video_out_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Write of a power-down pattern taken on the bus
	sequence s_pd(logic [3:0] v);
		psel && penable && pwrite && paddr == rpm_pkg::ADDR_POWER_CTRL
			&& pwdata[3:0] == v;
	endsequence

	a_off_no_term: assert property (s_pd(4'he) |-> ##2
		port_termination_en == 4'h0 && !link_core_en && !audio_out_oe)
		else $error("total power-down left a function on");
	a_sleep_term: assert property (s_pd(4'hd) |-> ##2
		port_termination_en == 4'hf && !link_core_en)
		else $error("link sleep lost termination or kept core");
	a_sleep_clkdet: assert property (s_pd(4'hd) |-> ##2
		clock_detect_en) else $error("clock detect off in link sleep");
	a_unsel_hiz: assert property (s_pd(4'h3) |-> ##2
		!audio_out_oe && !video_out_oe && sync_detect_en)
		else $error("unselected mode outputs not released");
	a_unsel_decrypt: assert property (s_pd(4'h3) |-> ##2
		decrypt_en) else $error("decryption stopped in unselected mode");
	a_full_run: assert property (s_pd(4'hf) |-> ##2
		audio_out_oe && video_out_oe && link_core_en && decrypt_en)
		else $error("full mode not fully running");
	a_ready_always: assert property (psel && penable |-> pready)
		else $error("register access stalled");
	a_one_port: assert property (link_core_en |-> $onehot(port_core_en))
		else $error("more or fewer than one port running");
	a_core_idle: assert property (!link_core_en |-> port_core_en == 4'h0)
		else $error("port logic running with core off");
endmodule : rpm_checker

bind rpm_power_ctrl rpm_checker u_rpm_checker (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready),
	.port_termination_en(port_termination_en), .port_core_en(port_core_en),
	.clock_detect_en(clock_detect_en), .sync_detect_en(sync_detect_en),
	.decrypt_en(decrypt_en), .link_core_en(link_core_en),
	.audio_out_oe(audio_out_oe), .video_out_oe(video_out_oe));

/* sim/tb.sv */
// Testbench: directed scenarios for power-mode control over APB
`timescale 1ns/1ps

module tb;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, lcp, lsp, clk_on = 0, sync_on = 0;
	logic        irq, se, cde, sde, dec, lce, aoe, voe, mck, xtl, apl, pck;
	logic [3:0]  term, core;
	int          error_cnt = 0, n_tests = 0;

	// Clock at 200 MHz
	initial forever #2.5 pclk = ~pclk;

	rpm_link_src u_rpm_link_src (.clk_on(clk_on), .sync_on(sync_on),
		.link_clock_present(lcp), .link_sync_present(lsp));
	rpm_power_ctrl u_rpm_power_ctrl (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link_clock_present(lcp),
		.link_sync_present(lsp), .port_termination_en(term),
		.port_core_en(core), .clock_detect_en(cde), .sync_detect_en(sde),
		.decrypt_en(dec), .link_core_en(lce), .audio_out_oe(aoe),
		.video_out_oe(voe), .master_audio_clock_powerdown_n(mck),
		.crystal_powerdown_n(xtl), .audio_pll_powerdown_n(apl),
		.pixel_clock_powerdown_n(pck), .irq(irq));

	task tally_and_finish;
		$display("errors %0d checks %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	// One APB transfer, then an idle cycle
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
		begin
			error_cnt++;
			tally_and_finish;
		end
		q = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : apb

	task t_reset;
		logic [11:0] ra [5] = '{rpm_pkg::ADDR_POWER_CTRL,
			rpm_pkg::ADDR_CLOCK_CTRL, rpm_pkg::ADDR_PORT_SEL,
			rpm_pkg::ADDR_IRQ_MASK, rpm_pkg::ADDR_MODE};
		logic [31:0] rv [5] = '{32'hf, 32'hf, 32'h0, 32'h0, 32'h1};
		for (int i = 0; i < 5; i++)
		begin
			apb(0, ra[i], 0);
			chk("reset value", q, rv[i]);
		end
		chk("clock controls", {pck, apl, xtl, mck}, 4'hf);
	endtask : t_reset

	task t_modes;
		logic [3:0] pd [5] = '{4'he, 4'hd, 4'h3, 4'h7, 4'hf};
		logic [3:0] te [5] = '{4'h0, 4'hf, 4'hf, 4'hf, 4'hf};
		logic       le [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
		logic       oe [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
		logic       ce [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
		logic [4:0] md [5] = '{5'h02, 5'h04, 5'h08, 5'h10, 5'h01};
		for (int i = 0; i < 5; i++)
		begin
			apb(1, rpm_pkg::ADDR_POWER_CTRL, {28'h0, pd[i]});
			cyc(2);
			chk("termination", term, te[i]);
			chk("link core", lce, le[i]);
			chk("clock detect", cde, ce[i]);
			chk("sync detect", sde, le[i]);
			chk("decrypt", dec, le[i]);
			chk("audio drive", aoe, oe[i]);
			chk("video drive", voe, oe[i]);
			apb(0, rpm_pkg::ADDR_MODE, 0);
			chk("mode", q, md[i]);
		end
	endtask : t_modes

	task t_ports;
		for (int p = 0; p < 4; p++)
		begin
			apb(1, rpm_pkg::ADDR_PORT_SEL, p);
			cyc(2);
			chk("port core", core, 4'h1 << p);
		end
	endtask : t_ports

	task t_clk;
		apb(1, rpm_pkg::ADDR_CLOCK_CTRL, 0); // Group all zero
		cyc(2);
		chk("clock group", {pck, apl, xtl, mck}, 4'h0);
		apb(1, rpm_pkg::ADDR_CLOCK_CTRL, 32'hf);
	endtask : t_clk

	task t_irq;
		apb(1, rpm_pkg::ADDR_POWER_CTRL, 32'hd);
		apb(1, rpm_pkg::ADDR_IRQ_STATUS, 32'h7);
		apb(1, rpm_pkg::ADDR_IRQ_MASK, 32'h1);
		chk("irq idle", irq, 1'b0);
		clk_on <= 1;
		cyc(4);
		apb(0, rpm_pkg::ADDR_STATUS, 0);
		chk("clock detected", q[0], 1'b1);
		chk("irq raised", irq, 1'b1);
		apb(1, rpm_pkg::ADDR_IRQ_STATUS, 32'h1);
		chk("irq cleared", irq, 1'b0);
		apb(1, rpm_pkg::ADDR_IRQ_MASK, 0);
		clk_on <= 0;
		cyc(4);
		chk("irq masked", irq, 1'b0);
		apb(0, rpm_pkg::ADDR_IRQ_STATUS, 0);
		chk("sticky bit", q[0], 1'b1);
		apb(1, rpm_pkg::ADDR_POWER_CTRL, 32'h3);
		sync_on <= 1;
		cyc(4);
		apb(0, rpm_pkg::ADDR_STATUS, 0);
		chk("sync detected", q[1], 1'b1);
		apb(0, rpm_pkg::ADDR_IRQ_STATUS, 0);
		chk("sync event", q[1], 1'b1);
		chk("mode event", q[2], 1'b1);
		chk("irq all masked", irq, 1'b0);
	endtask : t_irq

	task t_bad;
		apb(0, 12'h01c, 0);
		chk("unmapped error", se, 1'b1);
		chk("unmapped data", q, 32'h0);
	endtask : t_bad

	// Main sequence: reset, then scenarios
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_reset;
		t_modes;
		t_ports;
		t_clk;
		t_irq;
		t_bad;
		tally_and_finish;
	end
endmodule : tb
